// >>> ctlp_pkg.sv
package ctlp_pkg;
	// Timing, 250 MHz core clock
	localparam int CLK_NS        = 4;
	localparam int FILT_NS       = 50;
	localparam int FILT_CYC      = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam int INIT_CYC      = 3072;
	localparam int PLL_LOCK_MS   = 3;
	localparam int PLL_LOCK_CYC  = PLL_LOCK_MS * 1000000 / CLK_NS;
	localparam int CORE_LOAD_CYC = 32768;
	localparam int STRAP_EDGES   = 4;
	localparam int STRAP_MAJ     = 3;

	// Slave addresses, 7-bit form of 0x34 and 0x36
	localparam logic [6:0] ADDR_LOW  = 7'h1a;
	localparam logic [6:0] ADDR_HIGH = 7'h1b;

	// Register map
	localparam logic [15:0] REG_INIT    = 16'h0000;
	localparam logic [15:0] REG_STATUS  = 16'h0001;
	localparam logic [15:0] INIT_RESET  = 16'h0000;
	localparam int          PWR_BIT     = 0;
	localparam int          PLL_BIT     = 1;
	localparam int          DIV_LSB     = 2;
	localparam int          STS_STRAP   = 0;
	localparam int          STS_INIT    = 1;
	localparam int          STS_LOCK    = 2;
	localparam int          STS_CORE    = 3;

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK, S_IGNORE
	} ctlp_slv_t;

	typedef enum logic [1:0] {B_IDLE, B_START, B_BIT, B_STOP} ctlp_boot_t;

	// Bytes per word at a subaddress
	function automatic logic [2:0] word_len(input logic [15:0] a);
		case (a[15:12])
			4'h0:    word_len = 3'd2;
			4'h1:    word_len = 3'd4;
			4'h2:    word_len = 3'd6;
			default: word_len = 3'd1;
		endcase
	endfunction
endpackage

// >>> ctlp_glitch.sv
`timescale 1ns/1ns
module ctlp_glitch (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Raw line and clean level
	input  wire logic pin,
	output logic      q
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       q;
		logic [4:0] cnt;
	} ctlp_flt_t;

	ctlp_flt_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin;
		st_next.s2 = st_reg.s1;
		if (st_reg.s2 != st_reg.q) begin
			// Level must hold the full window before it is taken
			if (st_reg.cnt == 5'(ctlp_pkg::FILT_CYC - 1)) begin
				st_next.q = st_reg.s2;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 5'd1;
			end
		end else begin
			st_next.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, q: 1'b1, cnt: 5'h00};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_glitch_reject: assert property (
		$changed(st_reg.q) |-> $past(st_reg.cnt) == 5'(ctlp_pkg::FILT_CYC - 1))
		else $error("filtered line changed before the window");
endmodule

// >>> ctlp_top.sv
`timescale 1ns/1ns
// Summary of operation
// - SDA and SCL ignore pulses narrower than 50 ns.
// - Slave on the bus, master toward EEPROM only while self-booting.
// - Start is SDA falling with SCL high; idle watches for it.
// - First byte is 7-bit address plus direction, MSB first.
// - Matching address is acknowledged low on the ninth clock.
// - Other addresses send the slave back to idle, bus untouched.
// - Direction bit 0 means master writes, 1 means master reads.
// - Transfer runs until stop: SDA rising with SCL high.
// - Strap sampled on four master clock edges; low 0x34, high 0x36.
// - Port works up to 400 kHz serial clock.
// - Active-low reset; all blocks stay powered down after it.
// - Initialisation takes 3072 clocks after power-up.
// - System clock is master clock until PLL runs, then 122.88 MHz.
// - PLL locks about 3 ms after being enabled.
// - Default flow loads in 32768 clocks; core reports busy meanwhile.
// - Default flow loads only after a host write to register 0 sets the power bit.
// - Low mute input mutes every enabled output.
// - Master clock 24.576 MHz by default; dividers take slower ones.
// - Every written byte is acknowledged on the ninth clock.
// - Burst write advances subaddress after each full word.
// - Word length of one to six bytes decoded from subaddress.
module ctlp_top #(
	parameter int             PLL_LOCK_CYCLES = ctlp_pkg::PLL_LOCK_CYC,
	parameter int             CORE_LOAD_CYCLES = ctlp_pkg::CORE_LOAD_CYC,
	parameter logic [6:0]     EEPROM_ADDR     = 7'h50,
	parameter logic [7:0]     BOOT_BYTES      = 8'h10
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reset_n_pin,
	// Two-wire bus
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Straps and pins
	input  wire logic       addr_strap_pin,
	input  wire logic       master_clock_in,
	input  wire logic       mute_n_pin,
	// Core side
	input  wire logic       self_boot_req,
	output logic            boot_active,
	output logic [7:0]      boot_data,
	output logic            boot_valid,
	output logic            mute_out,
	output logic            blocks_powered,
	output logic            init_done,
	output logic            pll_locked,
	output logic            sysclk_pll_sel,
	output logic [1:0]      mclk_div_sel,
	output logic            core_ready
);
	localparam int LW = $clog2(PLL_LOCK_CYCLES + 1);
	localparam int CW = $clog2(CORE_LOAD_CYCLES + 1);

	typedef struct packed {
		logic                 rstn_s1, rstn_s2;
		logic                 mclk_s1, mclk_s2, mclk_s3;
		logic                 strap_s1, strap_s2;
		logic                 mute_s1, mute_s2;
		logic [2:0]           strap_cnt, strap_ones;
		logic                 strap_hi, strap_done;
		ctlp_pkg::ctlp_slv_t  slv;
		logic [3:0]           bcnt;
		logic [7:0]           shreg;
		logic                 rw;
		logic [15:0]          sub;
		logic [2:0]           bidx;
		logic [1:0]           hdr;
		logic [15:0]          wdata;
		logic [47:0]          rword;
		logic                 scl_p, sda_p;
		logic                 sda_oe, scl_oe;
		logic [15:0]          ctrl;
		logic                 mute;
		logic [11:0]          init_cnt;
		logic                 init_done;
		logic [LW-1:0]        lock_cnt;
		logic                 locked;
		logic [CW-1:0]        core_cnt;
		logic                 core_ready;
		ctlp_pkg::ctlp_boot_t boot;
		logic [7:0]           qcnt;
		logic [1:0]           ph;
		logic [3:0]           bbit;
		logic [8:0]           btx;
		logic [7:0]           brx;
		logic [7:0]           bbytes;
		logic                 bfirst, bnak;
		logic [7:0]           bdata;
		logic                 bvalid;
	} ctlp_state_t;

	ctlp_state_t st_reg, st_next;
	logic        scl_f, sda_f;

	ctlp_glitch u_scl_flt (.clk(clk), .rst(rst), .pin(scl_in), .q(scl_f));
	ctlp_glitch u_sda_flt (.clk(clk), .rst(rst), .pin(sda_in), .q(sda_f));

	logic        rise, fall, start_c, stop_c, tick;
	logic [6:0]  my_addr;
	logic [2:0]  wlen;
	logic [15:0] rd_val;
	logic [47:0] rd_word;
	logic [7:0]  wbyte;
	logic [15:0] wnew;

	always_comb begin
		ctlp_state_t r;
		r = '0;
		st_next = st_reg;
		rise = scl_f && !st_reg.scl_p;
		fall = !scl_f && st_reg.scl_p;
		start_c = scl_f && st_reg.scl_p && st_reg.sda_p && !sda_f;
		stop_c = scl_f && st_reg.scl_p && !st_reg.sda_p && sda_f;
		tick = st_reg.qcnt == 8'(ctlp_pkg::QTR_CYC - 1);
		my_addr = st_reg.strap_hi ? ctlp_pkg::ADDR_HIGH : ctlp_pkg::ADDR_LOW;
		wlen = ctlp_pkg::word_len(st_reg.sub);
		rd_val = '0;
		if (st_reg.sub == ctlp_pkg::REG_INIT) begin
			rd_val = st_reg.ctrl;
		end else if (st_reg.sub == ctlp_pkg::REG_STATUS) begin
			rd_val[ctlp_pkg::STS_STRAP] = st_reg.strap_hi;
			rd_val[ctlp_pkg::STS_INIT] = st_reg.init_done;
			rd_val[ctlp_pkg::STS_LOCK] = st_reg.locked;
			rd_val[ctlp_pkg::STS_CORE] = st_reg.core_ready;
		end
		rd_word = {32'h0000_0000, rd_val} << (8 * (6 - int'(wlen)));
		wbyte = st_reg.shreg;
		wnew = {st_reg.wdata[7:0], wbyte};

		st_next.rstn_s1 = reset_n_pin;
		st_next.rstn_s2 = st_reg.rstn_s1;
		st_next.mclk_s1 = master_clock_in;
		st_next.mclk_s2 = st_reg.mclk_s1;
		st_next.mclk_s3 = st_reg.mclk_s2;
		st_next.strap_s1 = addr_strap_pin;
		st_next.strap_s2 = st_reg.strap_s1;
		st_next.mute_s1 = mute_n_pin;
		st_next.mute_s2 = st_reg.mute_s1;
		st_next.scl_p = scl_f;
		st_next.sda_p = sda_f;
		st_next.mute = !st_reg.mute_s2;
		st_next.bvalid = 1'b0;

		// Address strap, majority of four master clock edges
		if (!st_reg.strap_done && st_reg.mclk_s2 && !st_reg.mclk_s3) begin
			st_next.strap_ones = st_reg.strap_ones + 3'(st_reg.strap_s2);
			st_next.strap_cnt = st_reg.strap_cnt + 3'd1;
			if (st_reg.strap_cnt == 3'(ctlp_pkg::STRAP_EDGES - 1)) begin
				st_next.strap_done = 1'b1;
				st_next.strap_hi = st_next.strap_ones >= 3'(ctlp_pkg::STRAP_MAJ);
			end
		end

		// Power-up sequencing
		if (!st_reg.init_done) begin
			st_next.init_cnt = st_reg.init_cnt + 12'd1;
			st_next.init_done = st_reg.init_cnt == 12'(ctlp_pkg::INIT_CYC - 1);
		end
		if (!st_reg.ctrl[ctlp_pkg::PLL_BIT]) begin
			st_next.lock_cnt = '0;
			st_next.locked = 1'b0;
		end else if (!st_reg.locked) begin
			st_next.lock_cnt = st_reg.lock_cnt + LW'(1);
			st_next.locked = st_reg.lock_cnt == LW'(PLL_LOCK_CYCLES - 1);
		end
		if (!st_reg.ctrl[ctlp_pkg::PWR_BIT]) begin
			st_next.core_cnt = '0;
			st_next.core_ready = 1'b0;
		end else if (st_reg.init_done && !st_reg.core_ready) begin
			st_next.core_cnt = st_reg.core_cnt + CW'(1);
			st_next.core_ready = st_reg.core_cnt == CW'(CORE_LOAD_CYCLES - 1);
		end

		// Slave side, idle while self-booting
		if (st_reg.boot != ctlp_pkg::B_IDLE) begin
			st_next.slv = ctlp_pkg::S_IDLE;
		end else if (stop_c) begin
			st_next.slv = ctlp_pkg::S_IDLE;
			st_next.sda_oe = 1'b0;
		end else if (start_c && st_reg.strap_done) begin
			st_next.slv = ctlp_pkg::S_ADDR;
			st_next.bcnt = '0;
			st_next.sda_oe = 1'b0;
		end else begin
			case (st_reg.slv)
				ctlp_pkg::S_ADDR, ctlp_pkg::S_WR: begin
					if (rise) begin
						st_next.shreg = {st_reg.shreg[6:0], sda_f};
						st_next.bcnt = st_reg.bcnt + 4'd1;
					end else if (fall && st_reg.bcnt == 4'd8) begin
						if (st_reg.slv == ctlp_pkg::S_WR) begin
							st_next.sda_oe = 1'b1;
							st_next.slv = ctlp_pkg::S_WR_ACK;
							if (st_reg.hdr != 2'd2) begin
								st_next.sub = {st_reg.sub[7:0], wbyte};
								st_next.hdr = st_reg.hdr + 2'd1;
								st_next.bidx = '0;
							end else begin
								st_next.wdata = wnew;
								if (st_reg.bidx == wlen - 3'd1) begin
									if (st_reg.sub == ctlp_pkg::REG_INIT) begin
										st_next.ctrl = wnew;
										if (!wnew[ctlp_pkg::PLL_BIT]) begin
											st_next.locked = 1'b0;
										end
									end
									st_next.sub = st_reg.sub + 16'h0001;
									st_next.bidx = '0;
								end else begin
									st_next.bidx = st_reg.bidx + 3'd1;
								end
							end
						end else if (st_reg.shreg[7:1] == my_addr) begin
							st_next.sda_oe = 1'b1;
							st_next.rw = st_reg.shreg[0];
							st_next.slv = ctlp_pkg::S_ADDR_ACK;
						end else begin
							st_next.slv = ctlp_pkg::S_IDLE;
						end
					end
				end
				ctlp_pkg::S_ADDR_ACK: begin
					if (fall) begin
						st_next.bidx = '0;
						if (st_reg.rw) begin
							st_next.sda_oe = !rd_word[47];
							st_next.rword = {rd_word[46:0], 1'b0};
							st_next.bcnt = 4'd1;
							st_next.slv = ctlp_pkg::S_RD;
						end else begin
							st_next.sda_oe = 1'b0;
							st_next.bcnt = '0;
							st_next.hdr = '0;
							st_next.slv = ctlp_pkg::S_WR;
						end
					end
				end
				ctlp_pkg::S_WR_ACK: begin
					if (fall) begin
						st_next.sda_oe = 1'b0;
						st_next.bcnt = '0;
						st_next.slv = ctlp_pkg::S_WR;
					end
				end
				ctlp_pkg::S_RD: begin
					if (fall) begin
						if (st_reg.bcnt == 4'd8) begin
							st_next.sda_oe = 1'b0;
							st_next.slv = ctlp_pkg::S_RD_ACK;
						end else begin
							st_next.sda_oe = !st_reg.rword[47];
							st_next.rword = {st_reg.rword[46:0], 1'b0};
							st_next.bcnt = st_reg.bcnt + 4'd1;
						end
					end
				end
				ctlp_pkg::S_RD_ACK: begin
					if (rise && sda_f) begin
						st_next.slv = ctlp_pkg::S_IGNORE;
					end else if (fall) begin
						st_next.bcnt = 4'd1;
						st_next.slv = ctlp_pkg::S_RD;
						if (st_reg.bidx == wlen - 3'd1) begin
							st_next.sub = st_reg.sub + 16'h0001;
							st_next.bidx = '0;
							r.rword = {32'h0000_0000, st_reg.ctrl};
							st_next.rword = st_reg.sub + 16'h0001 ==
								ctlp_pkg::REG_INIT ? r.rword : '0;
							st_next.sda_oe = 1'b0;
							st_next.bcnt = 4'd0;
							st_next.slv = ctlp_pkg::S_IGNORE;
							if (st_reg.sub + 16'h0001 != ctlp_pkg::REG_INIT) begin
								st_next.sub = st_reg.sub + 16'h0001;
							end
						end else begin
							st_next.bidx = st_reg.bidx + 3'd1;
							st_next.sda_oe = !st_reg.rword[47];
							st_next.rword = {st_reg.rword[46:0], 1'b0};
						end
					end
				end
				default: st_next.sda_oe = 1'b0;
			endcase
		end

		// Self-boot master toward the EEPROM
		st_next.qcnt = (tick || st_reg.boot == ctlp_pkg::B_IDLE) ?
			8'h00 : st_reg.qcnt + 8'h01;
		if (st_reg.boot != ctlp_pkg::B_IDLE && tick) begin
			st_next.ph = st_reg.ph + 2'd1;
		end
		case (st_reg.boot)
			ctlp_pkg::B_IDLE: begin
				if (self_boot_req && st_reg.slv == ctlp_pkg::S_IDLE &&
						st_reg.strap_done) begin
					st_next.boot = ctlp_pkg::B_START;
					st_next.ph = '0;
					st_next.sda_oe = 1'b0;
					st_next.bfirst = 1'b1;
					st_next.bnak = 1'b0;
					st_next.bbytes = '0;
				end
			end
			ctlp_pkg::B_START: begin
				if (tick && st_reg.ph == 2'd2) begin
					st_next.sda_oe = 1'b1;
				end
				if (tick && st_reg.ph == 2'd3) begin
					st_next.scl_oe = 1'b1;
					st_next.bbit = '0;
					st_next.btx = {EEPROM_ADDR, 1'b1, 1'b1};
					st_next.boot = ctlp_pkg::B_BIT;
				end
			end
			ctlp_pkg::B_BIT: begin
				if (tick) begin
					case (st_reg.ph)
						2'd0: st_next.sda_oe = !st_reg.btx[8];
						2'd1: st_next.scl_oe = 1'b0;
						2'd2: begin
							if (st_reg.bbit != 4'd8) begin
								st_next.brx = {st_reg.brx[6:0], sda_f};
							end else if (st_reg.bfirst && sda_f) begin
								st_next.bnak = 1'b1;
							end
						end
						default: begin
							st_next.scl_oe = 1'b1;
							st_next.btx = {st_reg.btx[7:0], 1'b1};
							st_next.bbit = st_reg.bbit + 4'd1;
							if (st_reg.bbit == 4'd8) begin
								st_next.bbit = '0;
								st_next.bfirst = 1'b0;
								st_next.btx = {8'hff, (st_reg.bfirst ? 8'h00 :
									st_reg.bbytes + 8'h01) >= BOOT_BYTES - 8'h01};
								if (!st_reg.bfirst) begin
									st_next.bdata = st_reg.brx;
									st_next.bvalid = 1'b1;
									st_next.bbytes = st_reg.bbytes + 8'h01;
								end
								if (st_reg.bnak || (!st_reg.bfirst &&
										st_reg.bbytes + 8'h01 == BOOT_BYTES)) begin
									st_next.boot = ctlp_pkg::B_STOP;
								end
							end
						end
					endcase
				end
			end
			ctlp_pkg::B_STOP: begin
				if (tick) begin
					case (st_reg.ph)
						2'd0: st_next.sda_oe = 1'b1;
						2'd1: st_next.scl_oe = 1'b0;
						2'd2: st_next.sda_oe = 1'b0;
						default: st_next.boot = ctlp_pkg::B_IDLE;
					endcase
				end
			end
			default: st_next.boot = ctlp_pkg::B_IDLE;
		endcase

		// Pin reset holds everything but the synchronisers
		if (!st_reg.rstn_s2) begin
			r = '0;
			r.ctrl = ctlp_pkg::INIT_RESET;
			r.rstn_s1 = st_next.rstn_s1;
			r.rstn_s2 = st_next.rstn_s2;
			r.mclk_s1 = st_next.mclk_s1;
			r.mclk_s2 = st_next.mclk_s2;
			r.mclk_s3 = st_next.mclk_s3;
			r.strap_s1 = st_next.strap_s1;
			r.strap_s2 = st_next.strap_s2;
			r.mute_s1 = st_next.mute_s1;
			r.mute_s2 = st_next.mute_s2;
			r.scl_p = st_next.scl_p;
			r.sda_p = st_next.sda_p;
			st_next = r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = st_reg.scl_oe;
	assign sda_oe = st_reg.sda_oe;
	assign boot_active = st_reg.boot != ctlp_pkg::B_IDLE;
	assign boot_data = st_reg.bdata;
	assign boot_valid = st_reg.bvalid;
	assign mute_out = st_reg.mute;
	assign blocks_powered = st_reg.ctrl[ctlp_pkg::PWR_BIT];
	assign init_done = st_reg.init_done;
	assign pll_locked = st_reg.locked;
	assign sysclk_pll_sel = st_reg.locked;
	assign mclk_div_sel = st_reg.ctrl[ctlp_pkg::DIV_LSB +: 2];
	assign core_ready = st_reg.core_ready;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_addr_ack_low: assert property (
		st_reg.slv == ctlp_pkg::S_ADDR_ACK |-> st_reg.sda_oe)
		else $error("address ack not driven");
	a_idle_released: assert property (
		st_reg.slv == ctlp_pkg::S_IDLE && st_reg.boot == ctlp_pkg::B_IDLE
		|-> !st_reg.sda_oe)
		else $error("idle slave drives SDA");
	a_rd_scl_low: assert property (
		$past(st_reg.slv) == ctlp_pkg::S_RD && $changed(st_reg.sda_oe)
		|-> !st_reg.scl_p)
		else $error("read data changed while SCL high");
	a_nack_release: assert property (
		st_reg.slv == ctlp_pkg::S_RD_ACK && rise && sda_f && !stop_c
		&& !start_c |=> st_reg.slv == ctlp_pkg::S_IGNORE ##1 !st_reg.sda_oe)
		else $error("nack did not end the read");
	a_init_length: assert property (
		$rose(st_reg.init_done) |-> $past(st_reg.init_cnt) == 12'd3071)
		else $error("init time wrong");
	a_sysclk_sel: assert property (
		sysclk_pll_sel |-> st_reg.ctrl[ctlp_pkg::PLL_BIT])
		else $error("PLL clock selected while PLL off");
	a_core_busy: assert property (
		$rose(st_reg.core_ready) |-> $past(st_reg.core_cnt)
		== CW'(CORE_LOAD_CYCLES - 1) && st_reg.ctrl[ctlp_pkg::PWR_BIT])
		else $error("core ready too early");
	a_mute_follow: assert property (
		!st_reg.mute_s2 && st_reg.rstn_s2 |=> st_reg.mute)
		else $error("mute not applied");
	a_boot_excl: assert property (
		st_reg.boot != ctlp_pkg::B_IDLE |=> st_reg.slv == ctlp_pkg::S_IDLE)
		else $error("slave active during boot");
	a_pin_reset: assert property (
		!st_reg.rstn_s2 |=> st_reg.ctrl == ctlp_pkg::INIT_RESET)
		else $error("power control not cleared by reset pin");

	c_write_init: cover property (
		st_reg.slv == ctlp_pkg::S_WR_ACK && $changed(st_reg.ctrl));
	c_read_nack: cover property (st_reg.slv == ctlp_pkg::S_IGNORE);
	c_boot_done: cover property ($fell(boot_active));
	c_strap_high: cover property (st_reg.strap_done && st_reg.strap_hi);
endmodule

// >>> ctlp_host_model.sv
`timescale 1ns/1ns
module ctlp_host_model #(
	parameter int         QTR     = 157,
	parameter logic [7:0] EE_DATA = 8'ha5
) (
	// Clock
	input  wire logic clk,
	// Resolved bus wires and the boot-active flag
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic boot,
	// Open-drain pulls, high pulls the wire low
	output logic      scl_low,
	output logic      sda_low,
	output logic      ee_sda_low
);
	logic       scl_d;
	logic       sda_d;
	logic [4:0] fall_cnt;
	logic [7:0] ee_sh;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Quarter of a 398 kHz bit period
	task automatic wait_q();
		repeat (QTR) @(posedge clk);
	endtask

	// Also serves as repeated start from SCL low
	task automatic start();
		sda_low <= 1'b0;
		wait_q();
		scl_low <= 1'b0;
		wait_q();
		sda_low <= 1'b1;
		wait_q();
		scl_low <= 1'b1;
		wait_q();
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		wait_q();
		scl_low <= 1'b0;
		wait_q();
		sda_low <= 1'b0;
		wait_q();
	endtask

	// Optional 40 ns SCL spike in the low phase
	task automatic bit_io(input logic b, input logic g, output logic r);
		sda_low <= ~b;
		if (g) begin
			repeat (20) @(posedge clk);
			scl_low <= 1'b0;
			repeat (10) @(posedge clk);
			scl_low <= 1'b1;
		end
		wait_q();
		scl_low <= 1'b0;
		wait_q();
		r = sda;
		wait_q();
		scl_low <= 1'b1;
		wait_q();
	endtask

	// Byte MSB first, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		input logic g, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], g && i == 7, r[i]);
		bit_io(ack_in, 1'b0, ack);
	endtask

	// EEPROM side of self-boot, counts SCL falls since start
	always @(posedge clk) begin
		scl_d <= scl;
		sda_d <= sda;
		if (!boot || (scl_d && scl && sda_d && !sda))
			fall_cnt <= 5'h00;
		else if (scl_d && !scl)
			fall_cnt <= fall_cnt + 5'h01;
	end

	assign ee_sh = EE_DATA << (fall_cnt - 5'h0a);
	// Ack the address, then shift the byte out
	assign ee_sda_low = boot && (fall_cnt == 5'h09 ||
		(fall_cnt >= 5'h0a && fall_cnt <= 5'h11 && !ee_sh[7]));
endmodule

// >>> test_control_port_and_init.sv
`timescale 1ns/1ns
module test_control_port_and_init;
	logic       clk, rst, reset_n_pin, addr_strap_pin, master_clock_in;
	logic       mute_n_pin, self_boot_req, scl, sda, scl_oe, sda_oe;
	logic       m_scl_low, m_sda_low, ee_sda_low, boot_active, boot_valid;
	logic       mute_out, blocks_powered, init_done, pll_locked;
	logic       sysclk_pll_sel, core_ready;
	logic [7:0] boot_data;
	logic [1:0] mclk_div_sel;
	int         num_errors, cmp_count;

	// Pull-ups on both wires
	assign scl = !(scl_oe || m_scl_low);
	assign sda = !(sda_oe || m_sda_low || ee_sda_low);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		master_clock_in = 1'b0;
		forever #20 master_clock_in = ~master_clock_in;
	end

	ctlp_top #(.PLL_LOCK_CYCLES(20), .CORE_LOAD_CYCLES(16),
		.BOOT_BYTES(8'h01)) uut (
		.clk(clk), .rst(rst), .reset_n_pin(reset_n_pin),
		.scl_in(scl), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.addr_strap_pin(addr_strap_pin), .master_clock_in(master_clock_in),
		.mute_n_pin(mute_n_pin), .self_boot_req(self_boot_req),
		.boot_active(boot_active), .boot_data(boot_data),
		.boot_valid(boot_valid), .mute_out(mute_out),
		.blocks_powered(blocks_powered), .init_done(init_done),
		.pll_locked(pll_locked), .sysclk_pll_sel(sysclk_pll_sel),
		.mclk_div_sel(mclk_div_sel), .core_ready(core_ready));

	ctlp_host_model h (
		.clk(clk), .scl(scl), .sda(sda), .boot(boot_active),
		.scl_low(m_scl_low), .sda_low(m_sda_low), .ee_sda_low(ee_sda_low));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Word write, glitch on the first bit of the first data byte
	task automatic wr(input logic [15:0] sub, input logic [15:0] val);
		logic [39:0] b;
		logic [7:0]  r;
		logic        a;
		b = {8'h34, sub, val};
		h.start();
		for (int i = 0; i < 5; i++) begin
			h.xfer(b[39 - 8 * i -: 8], 1'b1, i == 3, r, a);
			chk(a, 1'b0);
		end
		h.stop();
	endtask

	initial begin
		logic [7:0] r;
		logic       a;
		int         i;
		rst = 1'b1;
		reset_n_pin = 1'b1;
		addr_strap_pin = 1'b0;
		mute_n_pin = 1'b1;
		self_boot_req = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3000) @(posedge clk);
		chk(init_done, 1'b0);
		chk(blocks_powered, 1'b0);
		repeat (100) @(posedge clk);
		chk(init_done, 1'b1);
		mute_n_pin <= 1'b0;
		repeat (5) @(posedge clk);
		chk(mute_out, 1'b1);
		mute_n_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk(mute_out, 1'b0);
		wr(16'h0000, 16'h000b);
		chk(blocks_powered, 1'b1);
		chk(pll_locked, 1'b1);
		chk(sysclk_pll_sel, 1'b1);
		chk(mclk_div_sel, 2'h2);
		chk(core_ready, 1'b1);
		h.start();
		h.xfer(8'h34, 1'b1, 1'b0, r, a);
		h.xfer(8'h00, 1'b1, 1'b0, r, a);
		h.xfer(8'h01, 1'b1, 1'b0, r, a);
		h.start();
		h.xfer(8'h35, 1'b1, 1'b0, r, a);
		chk(a, 1'b0);
		h.xfer(8'hff, 1'b0, 1'b0, r, a);
		chk(r, 8'h00);
		h.xfer(8'hff, 1'b1, 1'b0, r, a);
		chk(r, 8'h0e);
		h.stop();
		// Pin reset with the strap now high
		addr_strap_pin <= 1'b1;
		reset_n_pin <= 1'b0;
		repeat (10) @(posedge clk);
		chk(blocks_powered, 1'b0);
		chk(pll_locked, 1'b0);
		reset_n_pin <= 1'b1;
		repeat (100) @(posedge clk);
		chk(init_done, 1'b0);
		h.start();
		h.xfer(8'h34, 1'b1, 1'b0, r, a);
		chk(a, 1'b1);
		h.start();
		h.xfer(8'h36, 1'b1, 1'b0, r, a);
		chk(a, 1'b0);
		h.stop();
		// Host stays off the bus from here on
		self_boot_req <= 1'b1;
		@(posedge clk);
		self_boot_req <= 1'b0;
		for (i = 0; i < 15000 && boot_valid !== 1'b1; i++)
			@(posedge clk);
		chk(boot_valid, 1'b1);
		chk(boot_data, 8'ha5);
		for (i = 0; i < 3000 && boot_active !== 1'b0; i++)
			@(posedge clk);
		chk(boot_active, 1'b0);
		print_verdict();
	end

	initial begin
		repeat (99000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
endmodule
